// ### logic/sysopt_regs.sv
/*
 * System option and power-management control register bank.
 * Assumes: register port strobes are one cycle and never both at once;
 * the low-voltage detector, oscillators and timer muxes are outside and
 * use the control outputs; power_on_rst marks the first power-up only.
 */
// Behaviour
// - Watchdog enable resets set, first write only
// - Watchdog clock select resets clear, write-once
// - Stop allow resets clear, write-once
// - Radio enable kept across reset, always writable
// - Temperature restart enable cleared by reset
// - Temperature restart level cleared by reset
// - Debug pin enable gives pin to debug
// - Option 1 bit 0 reads one
// - Option 2 bit 7 reads zero
// - Watchdog timeout resets longest, write-once
// - Timer source: port line or slow oscillator
// - Timer source divided by one or eight
// - Bus select codes give 4,2,1,0.5 MHz
// - Bus clock half fast oscillator; reset clear
// - Power control bit 1 reads zero
// - Detect and reset enables write-once
// - Flag set by event, acknowledge clears it
// - Interrupt request when flag and enable
`default_nettype none

module sysopt_regs
	import sysopt_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic power_on_rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Low-voltage detector
	input wire logic lowv_event,
	// Controls
	output logic wdog_enable,
	output logic wdog_clock_select,
	output logic stop_allow,
	output logic radio_enable,
	output logic temp_restart_enable,
	output logic temp_restart_level,
	output logic debug_pin_enable,
	output logic [2:0] wdog_timeout_sel,
	output logic tmr_ch0_src_sel,
	output logic tmr_ch0_src_div,
	output logic [1:0] bus_clock_sel,
	output logic lowv_irq,
	output logic lowv_reset_enable,
	output logic lowv_stop_enable,
	output logic lowv_detect_enable,
	output logic bandgap_buffer_enable
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Full address compare: a partial decode would let stray writes arm write-once latches
	logic wr_opt1, wr_opt2, wr_pmc1;
	assign wr_opt1 = reg_wr && (reg_addr == OFS_OPT1);
	assign wr_opt2 = reg_wr && (reg_addr == OFS_OPT2);
	assign wr_pmc1 = reg_wr && (reg_addr == OFS_PMC1);

	// ----------------------------------------------------------------
	// Option register 1
	// ----------------------------------------------------------------
	logic opt1_done_r;
	logic wdog_en_r, wdog_clk_r, stop_allow_r;
	logic radio_en_r;
	logic temp_en_r, temp_lvl_r, debug_pin_r;

	// One latch guards all write-once bits of this register; any write
	// arms it, even one that leaves the stored value unchanged
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			opt1_done_r <= 1'b0;
		end else if (wr_opt1) begin
			opt1_done_r <= 1'b1;
		end
	end

	// Write-once watchdog and stop controls
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wdog_en_r <= 1'b1;
			wdog_clk_r <= 1'b0;
			stop_allow_r <= 1'b0;
		end else if (wr_opt1 && !opt1_done_r) begin
			wdog_en_r <= reg_wdata[WDOG_EN_BIT];
			wdog_clk_r <= reg_wdata[WDOG_CLK_BIT];
			stop_allow_r <= reg_wdata[STOP_ALLOW_BIT];
		end
	end

	// Freely writable temperature restart and debug pin controls
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			temp_en_r <= 1'b0;
			temp_lvl_r <= 1'b0;
			debug_pin_r <= DEBUG_PIN_RST;
		end else if (wr_opt1) begin
			temp_en_r <= reg_wdata[TEMP_EN_BIT];
			temp_lvl_r <= reg_wdata[TEMP_LVL_BIT];
			debug_pin_r <= reg_wdata[DEBUG_PIN_BIT];
		end
	end

	// Radio enable survives ordinary resets; only power-up clears it, so
	// the system must pulse power_on_rst once or the bit starts unknown
	always_ff @(posedge core_clk) begin
		if (power_on_rst) begin
			radio_en_r <= RADIO_EN_RST;
		end else if (wr_opt1) begin
			radio_en_r <= reg_wdata[RADIO_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Option register 2
	// ----------------------------------------------------------------
	logic wdog_to_done_r;
	logic [2:0] wdog_to_r;
	logic tmr_src_r, tmr_div_r;
	logic [1:0] bus_sel_r;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wdog_to_done_r <= 1'b0;
		end else if (wr_opt2) begin
			wdog_to_done_r <= 1'b1;
		end
	end

	// Timeout field takes only the first write after reset
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wdog_to_r <= WDOG_TO_RST;
		end else if (wr_opt2 && !wdog_to_done_r) begin
			wdog_to_r <= reg_wdata[WDOG_TO_LSB +: WDOG_TO_W];
		end
	end

	// Timer source and bus clock code stay writable at any time
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tmr_src_r <= 1'b0;
			tmr_div_r <= 1'b0;
			bus_sel_r <= BUS_4MHZ;
		end else if (wr_opt2) begin
			tmr_src_r <= reg_wdata[TMR_SRC_BIT];
			tmr_div_r <= reg_wdata[TMR_DIV_BIT];
			bus_sel_r <= reg_wdata[BUS_SEL_LSB +: BUS_SEL_W];
		end
	end

	// ----------------------------------------------------------------
	// Power management control 1
	// ----------------------------------------------------------------
	logic pmc1_done_r;
	logic lv_flag_r, lv_irq_en_r, lv_rst_r, lv_stop_r, lv_det_r, bandgap_r;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pmc1_done_r <= 1'b0;
		end else if (wr_pmc1) begin
			pmc1_done_r <= 1'b1;
		end
	end

	// Detect and its reset take only the first write; a later write
	// cannot switch off protection that firmware set up at boot
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lv_rst_r <= PMC1_RST[LV_RST_BIT];
			lv_det_r <= PMC1_RST[LV_DET_BIT];
		end else if (wr_pmc1 && !pmc1_done_r) begin
			lv_rst_r <= reg_wdata[LV_RST_BIT];
			lv_det_r <= reg_wdata[LV_DET_BIT];
		end
	end

	// Interrupt, stop and bandgap enables are plain read/write bits
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lv_irq_en_r <= PMC1_RST[LV_IRQ_BIT];
			lv_stop_r <= PMC1_RST[LV_STOP_BIT];
			bandgap_r <= PMC1_RST[BANDGAP_BIT];
		end else if (wr_pmc1) begin
			lv_irq_en_r <= reg_wdata[LV_IRQ_BIT];
			lv_stop_r <= reg_wdata[LV_STOP_BIT];
			bandgap_r <= reg_wdata[BANDGAP_BIT];
		end
	end

	// Event beats a same-cycle acknowledge so no detection is lost
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lv_flag_r <= PMC1_RST[LV_FLAG_BIT];
		end else if (lowv_event && lv_det_r) begin
			lv_flag_r <= 1'b1;
		end else if (wr_pmc1 && reg_wdata[LV_ACK_BIT]) begin
			lv_flag_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	// Register images as software sees them; reserved bits are tied here
	logic [7:0] opt1_img;
	logic [7:0] opt2_img;
	logic [7:0] pmc1_img;
	assign opt1_img = {wdog_en_r, wdog_clk_r, stop_allow_r, radio_en_r,
		temp_en_r, temp_lvl_r, debug_pin_r, 1'b1};
	assign opt2_img = {1'b0, wdog_to_r, tmr_src_r, tmr_div_r, bus_sel_r};
	// Acknowledge is write-only and bit 1 is reserved: both read zero
	assign pmc1_img = {lv_flag_r, 1'b0, lv_irq_en_r, lv_rst_r,
		lv_stop_r, lv_det_r, 1'b0, bandgap_r};

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr)
			OFS_OPT1: begin
				rd_mux = opt1_img;
			end
			OFS_OPT2: begin
				rd_mux = opt2_img;
			end
			OFS_PMC1: begin
				rd_mux = pmc1_img;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// Read data is zero outside its answer cycle so an OR of slaves stays clean
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Control outputs, each from a flip-flop
	// ----------------------------------------------------------------
	// Registered so the request never glitches while the register is written
	logic lv_irq_r;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lv_irq_r <= 1'b0;
		end else begin
			lv_irq_r <= lv_flag_r && lv_irq_en_r;
		end
	end

	// Controls come straight from their registers, with no logic after them
	assign lowv_irq = lv_irq_r;
	assign wdog_enable = wdog_en_r;
	assign wdog_clock_select = wdog_clk_r;
	assign stop_allow = stop_allow_r;
	assign radio_enable = radio_en_r;
	assign temp_restart_enable = temp_en_r;
	assign temp_restart_level = temp_lvl_r;
	assign debug_pin_enable = debug_pin_r;
	assign wdog_timeout_sel = wdog_to_r;
	assign tmr_ch0_src_sel = tmr_src_r;
	assign tmr_ch0_src_div = tmr_div_r;
	assign bus_clock_sel = bus_sel_r;
	assign lowv_reset_enable = lv_rst_r;
	assign lowv_stop_enable = lv_stop_r;
	assign lowv_detect_enable = lv_det_r;
	assign bandgap_buffer_enable = bandgap_r;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The field layout must fit the byte-wide register port
	if (WDOG_TO_LSB + WDOG_TO_W > 7) begin : g_bad_timeout_field
		$error("watchdog timeout field overlaps bit 7");
	end
	if (BUS_SEL_LSB + BUS_SEL_W > TMR_DIV_BIT) begin : g_bad_bus_field
		$error("bus clock field overlaps the timer divider bit");
	end
	if (PMC1_RST[LV_ACK_BIT] != 1'b0) begin : g_bad_ack_reset
		$error("acknowledge bit must reset to zero");
	end

endmodule : sysopt_regs

`default_nettype wire

// ### logic/sysopt_pkg.sv
/*
 * Package for the system option and power-management register bank:
 * register offsets, field positions, reset values and bus clock codes.
 * Assumes a byte-wide register port from the on-chip core.
 */
`default_nettype none

package sysopt_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] OFS_PMC1 = 16'h1809;
	localparam logic [15:0] OFS_OPT1 = 16'h1802;
	localparam logic [15:0] OFS_OPT2 = 16'h1803;
	localparam logic [15:0] OFS_LVIN = 16'h1810;

	// ----------------------------------------------------------------
	// Option register 1 fields
	// ----------------------------------------------------------------
	localparam int WDOG_EN_BIT = 7;
	localparam int WDOG_CLK_BIT = 6;
	localparam int STOP_ALLOW_BIT = 5;
	localparam int RADIO_EN_BIT = 4;
	localparam int TEMP_EN_BIT = 3;
	localparam int TEMP_LVL_BIT = 2;
	localparam int DEBUG_PIN_BIT = 1;
	localparam int OPT1_RSVD_BIT = 0;
	localparam logic DEBUG_PIN_RST = 1'h1;
	localparam logic RADIO_EN_RST = 1'h0;

	// ----------------------------------------------------------------
	// Option register 2 fields
	// ----------------------------------------------------------------
	localparam int WDOG_TO_LSB = 4;
	localparam int WDOG_TO_W = 3;
	localparam logic [2:0] WDOG_TO_RST = 3'h7;
	localparam int TMR_SRC_BIT = 3;
	localparam int TMR_DIV_BIT = 2;
	localparam int BUS_SEL_LSB = 0;
	localparam int BUS_SEL_W = 2;
	localparam int TMR_DIV_RATIO = 8;

	// ----------------------------------------------------------------
	// Power management control 1 fields
	// ----------------------------------------------------------------
	localparam int LV_FLAG_BIT = 7;
	localparam int LV_ACK_BIT = 6;
	localparam int LV_IRQ_BIT = 5;
	localparam int LV_RST_BIT = 4;
	localparam int LV_STOP_BIT = 3;
	localparam int LV_DET_BIT = 2;
	localparam int BANDGAP_BIT = 0;
	localparam logic [7:0] PMC1_RST = 8'h1C;

	// Bus clock select codes
	typedef enum logic [1:0] {
		BUS_4MHZ = 2'h0,
		BUS_2MHZ = 2'h1,
		BUS_1MHZ = 2'h2,
		BUS_HALF_MHZ = 2'h3
	} bus_clk_t;

endpackage : sysopt_pkg

`default_nettype wire

// ### verif/sysopt_properties.sv
/* Port assertions for the register bank.
   Bound to sysopt_regs; one clock, synchronous reset. */
`default_nettype none
module sysopt_props
	import sysopt_pkg::*;
(
	// Clock, reset and register port
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic power_on_rst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Controls
	input wire logic wdog_enable,
	input wire logic wdog_clock_select,
	input wire logic stop_allow,
	input wire logic radio_enable,
	input wire logic temp_restart_enable,
	input wire logic temp_restart_level,
	input wire logic debug_pin_enable,
	input wire logic [2:0] wdog_timeout_sel,
	input wire logic tmr_ch0_src_sel,
	input wire logic tmr_ch0_src_div,
	input wire logic [1:0] bus_clock_sel,
	input wire logic lowv_reset_enable,
	input wire logic lowv_stop_enable,
	input wire logic lowv_detect_enable,
	input wire logic bandgap_buffer_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic opt1_done_r;
	// Mirrors the write-once latch so a later write can be judged
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			opt1_done_r <= 1'b0;
		else if (reg_wr && reg_addr == OFS_OPT1)
			opt1_done_r <= 1'b1;
	end
	sequence s_wr(a); reg_wr && reg_addr == a; endsequence
	sequence s_rd(a); reg_rd && reg_addr == a; endsequence
	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read");
	a_opt1_bit0_one: assert property (s_rd(OFS_OPT1) |=> reg_rdata[0])
		else $error("option 1 bit 0 read as zero");
	a_opt2_bit7_zero: assert property (s_rd(OFS_OPT2) |=> !reg_rdata[7])
		else $error("option 2 bit 7 read as one");
	a_pmc_rsvd_zero: assert property (s_rd(OFS_PMC1) |=> !reg_rdata[6] && !reg_rdata[1])
		else $error("power control bit 6 or 1 read as one");
	a_reset_opt_vals: assert property ($fell(sys_rst) |-> wdog_enable
		&& !wdog_clock_select && !stop_allow && wdog_timeout_sel == 3'h7 && bus_clock_sel == 2'h0
		&& !temp_restart_enable && !temp_restart_level && debug_pin_enable)
		else $error("option reset values wrong");
	a_reset_pmc_vals: assert property ($fell(sys_rst) |->
		{lowv_reset_enable, lowv_stop_enable, lowv_detect_enable, bandgap_buffer_enable} == 4'hE)
		else $error("power control reset values wrong");
	a_opt2_free_bits: assert property (s_wr(OFS_OPT2) |=>
		{tmr_ch0_src_sel, tmr_ch0_src_div, bus_clock_sel} == $past(reg_wdata[3:0]))
		else $error("option 2 free bits not written");
	a_opt1_free_bits: assert property (s_wr(OFS_OPT1) |=>
		{temp_restart_enable, temp_restart_level, debug_pin_enable} == $past(reg_wdata[3:1]))
		else $error("option 1 free bits not written");
	a_radio_any_time: assert property (s_wr(OFS_OPT1) ##0 !power_on_rst
		|=> radio_enable == $past(reg_wdata[4]))
		else $error("radio enable not written");
	a_opt1_write_once: assert property (opt1_done_r && reg_wr && reg_addr == OFS_OPT1
		|=> $stable({wdog_enable, wdog_clock_select, stop_allow}))
		else $error("write-once option bits changed");
endmodule : sysopt_props
bind sysopt_regs sysopt_props sysopt_props_inst (.core_clk, .sys_rst, .power_on_rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wdog_enable, .wdog_clock_select, .stop_allow,
	.radio_enable, .temp_restart_enable, .temp_restart_level, .debug_pin_enable,
	.wdog_timeout_sel, .tmr_ch0_src_sel, .tmr_ch0_src_div, .bus_clock_sel,
	.lowv_reset_enable, .lowv_stop_enable, .lowv_detect_enable, .bandgap_buffer_enable);
`default_nettype wire

// ### verif/testbench.sv
/* Self-checking bench for the register bank.
   Drives the register port itself; expects sysopt_pkg and the bound checker. */
`default_nettype none
module testbench
	import sysopt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic power_on_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic lowv_event = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] bus_clock_sel;
	logic lowv_irq;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	always #5 core_clk = ~core_clk;
	sysopt_regs sysopt_regs_inst (.core_clk, .sys_rst, .power_on_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .lowv_event, .wdog_enable(), .wdog_clock_select(),
		.stop_allow(), .radio_enable(), .temp_restart_enable(), .temp_restart_level(),
		.debug_pin_enable(), .wdog_timeout_sel(), .tmr_ch0_src_sel(), .tmr_ch0_src_div(),
		.bus_clock_sel, .lowv_irq, .lowv_reset_enable(), .lowv_stop_enable(),
		.lowv_detect_enable(), .bandgap_buffer_enable());
	task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : ck
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		ck($sformatf("reg %h", a), e, reg_rdata);
	endtask : rd
	task automatic test_done;
		$display("Errors %0d in %0d checks", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// Ceiling well above the roughly 75 cycles the sequence needs
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		power_on_rst <= 1'b0;
		rd(OFS_OPT1, 8'h83);
		rd(OFS_OPT2, 8'h70);
		rd(OFS_PMC1, 8'h1C);
		rd(16'h1FFF, 8'h00);
		wr(OFS_OPT1, 8'h7C);
		rd(OFS_OPT1, 8'h7D);
		wr(OFS_OPT1, 8'h80);
		rd(OFS_OPT1, 8'h61);
		wr(OFS_OPT2, 8'h85);
		rd(OFS_OPT2, 8'h05);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_OPT2, 8'h7C | 8'(c));
			ck("bus_clock_sel", 8'(c), {6'h00, bus_clock_sel});
			rd(OFS_OPT2, 8'h0C | 8'(c));
		end
		@(posedge core_clk);
		lowv_event <= 1'b1;
		@(posedge core_clk);
		lowv_event <= 1'b0;
		rd(OFS_PMC1, 8'h9C);
		ck("lowv_irq", 8'h00, {7'h00, lowv_irq});
		wr(OFS_PMC1, 8'h24);
		rd(OFS_PMC1, 8'hA4);
		ck("lowv_irq", 8'h01, {7'h00, lowv_irq});
		wr(OFS_PMC1, 8'h64);
		rd(OFS_PMC1, 8'h24);
		ck("lowv_irq", 8'h00, {7'h00, lowv_irq});
		wr(OFS_PMC1, 8'h39);
		rd(OFS_PMC1, 8'h2D);
		// Radio bit must survive a core reset
		wr(OFS_OPT1, 8'h10);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		@(posedge core_clk);
		sys_rst <= 1'b0;
		rd(OFS_OPT1, 8'h93);
		wr(OFS_OPT1, 8'h01);
		rd(OFS_OPT1, 8'h01);
		test_done();
	end
endmodule : testbench
`default_nettype wire
